// >>> verilog/pwoc_consts.vh
// Constants for the pin wake and output control block.
// Assumes inclusion by bare name from design files.
`ifndef PWOC_CONSTS_VH
`define PWOC_CONSTS_VH

// Input pin count and status word width
`define PWOC_NUM_PINS      21
`define PWOC_STAT_W        32
// Reset values
`define PWOC_WAKE_EN_RST   21'h00_0000
`define PWOC_EDGE_RST      21'h00_0000
`define PWOC_OUT_LVL_RST   2'h3
// Edge encoding: 0 rising, 1 falling
`define PWOC_EDGE_RISE     1'b0
`define PWOC_EDGE_FALL     1'b1
// Output indices
`define PWOC_OUT_FIRST     0
`define PWOC_OUT_SECOND    1

`endif

// >>> verilog/pwoc_pin_sync.v
// Two-stage synchroniser with edge detection for one input pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module pwoc_pin_sync (
   clk,
   rstn,
   pin_in,
   edge_fall,
   edge_hit
);
   input  wire clk;
   input  wire rstn;
   input  wire pin_in;
   input  wire edge_fall;
   output wire edge_hit;

   reg meta_q;
   reg sync_q;
   reg prev_q;

   always @(posedge clk) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q; // RULE23
         prev_q <= sync_q;
      end
   end

   // Edge on synchronised level only
   assign edge_hit = edge_fall ? (prev_q & ~sync_q)
                               : (~prev_q & sync_q); // RULE23
endmodule

// >>> verilog/pwoc_top.v
// Pin wake and output control: per-pin wake/interrupt enable and edge,
// read-to-clear event status, and two general output pins.
// Assumes software strobes on this clock; pins are asynchronous.
// Summary of operation
// RULE1 - Enabled pin edge raises a wake request out of sleep or doze.
// RULE2 - Enable mask sets wake enable, disable mask clears it.
// RULE3 - Pin in both enable and disable masks ends up disabled.
// RULE4 - Pins clear in both masks keep enable and edge unchanged.
// RULE5 - Enable and edge updates ignore pins not set as inputs.
// RULE6 - Wake enable and edge settings survive sleep and wake-up.
// RULE7 - Edge defaults rising; rising mask selects rising, falling falling.
// RULE8 - Pin in both rising and falling masks selects rising.
// RULE9 - Wake and interrupt controls share the same physical bits.
// RULE10 - Status read returns pin and other event flags, then clears all.
// RULE11 - Status bits above the pins hold the other event flags, not zero.
// RULE12 - Status of output or peripheral pins is undefined to software.
// RULE13 - Deep-sleep wake is a full reset, so status shows nothing.
// RULE14 - After ordinary sleep, status keeps accumulating boot events.
// RULE15 - One enable takes both outputs; SPI and timers then blocked.
// RULE16 - Enable request fails and takes nothing while SPI uses pins.
// RULE17 - Reset, sleep and wake return outputs disabled, pull-ups on.
// RULE18 - On mask drives output high, off mask drives it low.
// RULE19 - Both output levels are high after power-up.
// RULE20 - Both masks set drives low; neither set keeps the level.
// RULE21 - Levels reach a peripheral-owned pin only once it is freed.
// RULE22 - Software enables outputs and sees success before writing levels.
// RULE23 - Pins pass two flip-flops; enabled edge sets status next cycle.
`timescale 1ns/1ps
`include "pwoc_consts.vh"
module pwoc_top #(
   parameter NUM_PINS = `PWOC_NUM_PINS,
   parameter STAT_W   = `PWOC_STAT_W
) (
   clk,
   rstn,
   general_io_pin,
   pin_is_input,
   wake_en_upd,
   wake_enable_mask,
   wake_disable_mask,
   edge_upd,
   rising_edge_mask,
   falling_edge_mask,
   other_events,
   status_rd,
   status_rdata,
   status_rvalid,
   wake_enable,
   edge_falling,
   wake_req,
   sleep_active,
   wake_event,
   outputs_en_req,
   outputs_enable_flag,
   outputs_en_result,
   outputs_en_done,
   spi_owns_outputs,
   per_owns_outputs,
   out_lvl_upd,
   output_high_mask,
   output_low_mask,
   outputs_enabled,
   spi_timer_block,
   general_output_first,
   general_output_second,
   output_pullup_en
);
   input  wire                clk;
   input  wire                rstn;
   input  wire [NUM_PINS-1:0] general_io_pin;
   input  wire [NUM_PINS-1:0] pin_is_input;
   input  wire                wake_en_upd;
   input  wire [NUM_PINS-1:0] wake_enable_mask;
   input  wire [NUM_PINS-1:0] wake_disable_mask;
   input  wire                edge_upd;
   input  wire [NUM_PINS-1:0] rising_edge_mask;
   input  wire [NUM_PINS-1:0] falling_edge_mask;
   input  wire [STAT_W-NUM_PINS-1:0] other_events;
   input  wire                status_rd;
   output reg  [STAT_W-1:0]   status_rdata;
   output reg                 status_rvalid;
   output wire [NUM_PINS-1:0] wake_enable;
   output wire [NUM_PINS-1:0] edge_falling;
   output wire                wake_req;
   input  wire                sleep_active;
   input  wire                wake_event;
   input  wire                outputs_en_req;
   input  wire                outputs_enable_flag;
   output reg                 outputs_en_result;
   output reg                 outputs_en_done;
   input  wire                spi_owns_outputs;
   input  wire [1:0]          per_owns_outputs;
   input  wire                out_lvl_upd;
   input  wire [1:0]          output_high_mask;
   input  wire [1:0]          output_low_mask;
   output wire                outputs_enabled;
   output wire                spi_timer_block;
   output wire                general_output_first;
   output wire                general_output_second;
   output wire [1:0]          output_pullup_en;

   // ----------------------------------------------------------------
   // Wake / interrupt configuration
   // ----------------------------------------------------------------
   // One copy of each bit serves both the wake and interrupt views
   reg  [NUM_PINS-1:0] wake_en_q;   // RULE9
   reg  [NUM_PINS-1:0] wake_en_d;
   reg  [NUM_PINS-1:0] edge_q;      // RULE9
   reg  [NUM_PINS-1:0] edge_d;
   wire [NUM_PINS-1:0] en_sel;
   wire [NUM_PINS-1:0] edge_sel;

   assign en_sel   = (wake_enable_mask | wake_disable_mask) & pin_is_input;
   assign edge_sel = (rising_edge_mask | falling_edge_mask) & pin_is_input;

   always @* begin
      wake_en_d = wake_en_q;
      edge_d    = edge_q;
      if (wake_en_upd) begin
         // Disable mask wins when both are set
         wake_en_d = (wake_en_q & ~en_sel)
                   | (en_sel & wake_enable_mask
                      & ~wake_disable_mask); // RULE2 RULE3 RULE4 RULE5
      end
      if (edge_upd) begin
         // Rising wins when both are set
         edge_d = (edge_q & ~edge_sel)
                | (edge_sel & falling_edge_mask
                   & ~rising_edge_mask); // RULE7 RULE8 RULE4 RULE5
      end
   end

   // Only rstn clears settings; sleep and wake leave them alone
   always @(posedge clk) begin
      if (!rstn) begin
         wake_en_q <= `PWOC_WAKE_EN_RST;
         edge_q    <= `PWOC_EDGE_RST; // RULE7
      end else begin
         wake_en_q <= wake_en_d; // RULE6
         edge_q    <= edge_d;    // RULE6
      end
   end

   assign wake_enable  = wake_en_q;
   assign edge_falling = edge_q;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detectors
   // ----------------------------------------------------------------
   wire [NUM_PINS-1:0] pin_edge;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
         pwoc_pin_sync u_sync (
            .clk       (clk),
            .rstn      (rstn),
            .pin_in    (general_io_pin[gi]),
            .edge_fall (edge_q[gi]),
            .edge_hit  (pin_edge[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Event status, read to clear
   // ----------------------------------------------------------------
   // Pin events latch whether or not enabled, so status can be polled;
   // bits of non-input pins are not meaningful
   reg  [NUM_PINS-1:0]        pin_stat_q;   // RULE12
   reg  [NUM_PINS-1:0]        pin_stat_d;
   reg  [STAT_W-NUM_PINS-1:0] oth_stat_q;
   reg  [STAT_W-NUM_PINS-1:0] oth_stat_d;
   reg                        wake_req_q;

   always @* begin
      pin_stat_d = pin_stat_q;
      oth_stat_d = oth_stat_q;
      if (status_rd) begin
         pin_stat_d = {NUM_PINS{1'b0}};         // RULE10
         oth_stat_d = {(STAT_W-NUM_PINS){1'b0}}; // RULE10
      end
      // New events win over the read clear
      pin_stat_d = pin_stat_d | pin_edge;      // RULE23 RULE14
      oth_stat_d = oth_stat_d | other_events;
   end

   // Status clears on a read or on full reset (deep-sleep wake)
   always @(posedge clk) begin
      if (!rstn) begin
         pin_stat_q    <= {NUM_PINS{1'b0}}; // RULE13
         oth_stat_q    <= {(STAT_W-NUM_PINS){1'b0}};
         status_rdata  <= {STAT_W{1'b0}};
         status_rvalid <= 1'b0;
         wake_req_q    <= 1'b0;
      end else begin
         pin_stat_q    <= pin_stat_d;
         oth_stat_q    <= oth_stat_d;
         status_rvalid <= status_rd;
         if (status_rd) begin
            status_rdata <= {oth_stat_q, pin_stat_q}; // RULE10 RULE11
         end
         wake_req_q    <= |(pin_edge & wake_en_q & pin_is_input); // RULE1
      end
   end

   assign wake_req = wake_req_q;

   // ----------------------------------------------------------------
   // General output enable
   // ----------------------------------------------------------------
   reg outputs_en_q;
   reg outputs_en_d;

   always @* begin
      outputs_en_d = outputs_en_q;
      if (sleep_active || wake_event) begin
         outputs_en_d = 1'b0; // RULE17
      end else if (outputs_en_req) begin
         if (!outputs_enable_flag) begin
            outputs_en_d = 1'b0;
         end else if (!spi_owns_outputs) begin
            outputs_en_d = 1'b1; // RULE15
         end
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         outputs_en_q      <= 1'b0; // RULE17
         outputs_en_result <= 1'b0;
         outputs_en_done   <= 1'b0;
      end else begin
         outputs_en_q      <= outputs_en_d;
         outputs_en_done   <= outputs_en_req;
         if (outputs_en_req) begin
            outputs_en_result <= ~outputs_enable_flag
                               | ~spi_owns_outputs; // RULE16
         end
      end
   end

   assign outputs_enabled  = outputs_en_q;
   assign spi_timer_block  = outputs_en_q; // RULE15
   assign output_pullup_en = outputs_en_q ? 2'b00 : 2'b11; // RULE17

   // ----------------------------------------------------------------
   // General output levels
   // ----------------------------------------------------------------
   reg  [1:0] out_lvl_q;
   reg  [1:0] out_lvl_d;
   reg  [1:0] pin_lvl_q;
   wire [1:0] lvl_sel;

   assign lvl_sel = output_high_mask | output_low_mask;

   always @* begin
      out_lvl_d = out_lvl_q;
      if (out_lvl_upd) begin
         // Low wins when both are set
         out_lvl_d = (out_lvl_q & ~lvl_sel)
                   | (output_high_mask & ~output_low_mask); // RULE18 RULE20
      end
   end

   // Written level is held; a pin owned by a peripheral keeps its
   // last driven level until ownership is released
   always @(posedge clk) begin
      if (!rstn) begin
         out_lvl_q <= `PWOC_OUT_LVL_RST; // RULE19
         pin_lvl_q <= `PWOC_OUT_LVL_RST; // RULE19
      end else begin
         out_lvl_q <= out_lvl_d;
         if (!per_owns_outputs[`PWOC_OUT_FIRST]) begin
            pin_lvl_q[`PWOC_OUT_FIRST] <= out_lvl_q[`PWOC_OUT_FIRST]; // RULE21
         end
         if (!per_owns_outputs[`PWOC_OUT_SECOND]) begin
            pin_lvl_q[`PWOC_OUT_SECOND] <= out_lvl_q[`PWOC_OUT_SECOND]; // RULE21
         end
      end
   end

   assign general_output_first  = pin_lvl_q[`PWOC_OUT_FIRST];
   assign general_output_second = pin_lvl_q[`PWOC_OUT_SECOND];
endmodule

// >>> testbench/pwoc_assertions.sv
// Port checker for pwoc_top.
// Assumes it is bound onto every pwoc_top instance.
`timescale 1ns/1ps
module pwoc_assertions #(
   parameter NUM_PINS = 21
) (
   input logic                clk,
   input logic                rstn,
   input logic [NUM_PINS-1:0] pin_is_input,
   input logic                wake_en_upd,
   input logic [NUM_PINS-1:0] wake_enable_mask,
   input logic [NUM_PINS-1:0] wake_disable_mask,
   input logic                edge_upd,
   input logic [NUM_PINS-1:0] rising_edge_mask,
   input logic                status_rd,
   input logic                status_rvalid,
   input logic [NUM_PINS-1:0] wake_enable,
   input logic [NUM_PINS-1:0] edge_falling,
   input logic                sleep_active,
   input logic                wake_event,
   input logic                outputs_en_req,
   input logic                outputs_enable_flag,
   input logic                outputs_en_result,
   input logic                spi_owns_outputs,
   input logic                outputs_enabled,
   input logic                spi_timer_block,
   input logic                general_output_first,
   input logic                general_output_second,
   input logic [1:0]          output_pullup_en
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   logic [NUM_PINS-1:0] en_m;
   logic [NUM_PINS-1:0] dis_m;
   logic [NUM_PINS-1:0] ris_m;
   logic                en_go;
   assign en_m  = wake_enable_mask & ~wake_disable_mask & pin_is_input;
   assign dis_m = wake_disable_mask & pin_is_input;
   assign ris_m = rising_edge_mask & pin_is_input;
   assign en_go = outputs_en_req && outputs_enable_flag && !sleep_active;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_wake_set_bits: assert property (wake_en_upd |=>
      (wake_enable & $past(en_m)) == $past(en_m)) else $error("wake set");
   a_both_masks_off: assert property (wake_en_upd |=>
      (wake_enable & $past(dis_m)) == '0) else $error("wake clear");
   a_rising_wins: assert property (edge_upd |=>
      (edge_falling & $past(ris_m)) == '0) else $error("edge pick");
   a_read_answer: assert property (status_rd |=> status_rvalid)
      else $error("no read answer");
   a_enable_refused: assert property (en_go && spi_owns_outputs
      && !outputs_enabled |=> !outputs_en_result && !outputs_enabled)
      else $error("enable not refused");
   a_enable_taken: assert property (en_go && !spi_owns_outputs
      && !wake_event |=> outputs_en_result && outputs_enabled)
      else $error("enable not taken");
   a_block_ties: assert property (spi_timer_block == outputs_enabled)
      else $error("block mismatch");
   a_pullup_map: assert property
      (output_pullup_en == {2{!outputs_enabled}}) else $error("pullups");
   a_sleep_off: assert property (sleep_active |=> !outputs_enabled)
      else $error("sleep keeps outputs");
   a_level_init: assert property ($rose(rstn) |->
      general_output_first && general_output_second) else $error("levels");
   c_wake_upd: cover property (wake_en_upd);
   c_refused: cover property (outputs_en_req && spi_owns_outputs);
   c_read: cover property (status_rd ##1 status_rvalid);
endmodule
bind pwoc_top pwoc_assertions #(.NUM_PINS(NUM_PINS)) i_pwoc_assertions (
   .clk(clk), .rstn(rstn), .pin_is_input(pin_is_input),
   .wake_en_upd(wake_en_upd), .wake_enable_mask(wake_enable_mask),
   .wake_disable_mask(wake_disable_mask), .edge_upd(edge_upd),
   .rising_edge_mask(rising_edge_mask), .status_rd(status_rd),
   .status_rvalid(status_rvalid), .wake_enable(wake_enable),
   .edge_falling(edge_falling), .sleep_active(sleep_active),
   .wake_event(wake_event), .outputs_en_req(outputs_en_req),
   .outputs_enable_flag(outputs_enable_flag),
   .outputs_en_result(outputs_en_result),
   .spi_owns_outputs(spi_owns_outputs), .outputs_enabled(outputs_enabled),
   .spi_timer_block(spi_timer_block),
   .general_output_first(general_output_first),
   .general_output_second(general_output_second),
   .output_pullup_en(output_pullup_en));

// >>> testbench/pwoc_pin_model.sv
// External pin driver model for the general input pins.
// Assumes target levels are commanded by the bench.
`timescale 1ns/1ps
module pwoc_pin_model (
   input  logic [20:0] target,
   output logic [20:0] pins
);
   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   // Lands off the clock grid, as a real asynchronous pin does
   assign #37 pins = target;
endmodule

// >>> testbench/pwoc_top_tb_top.sv
// Self-checking bench for pwoc_top.
// Assumes pwoc_pin_model drives pins and the checker is bound.
`timescale 1ns/1ps
module pwoc_top_tb_top;
   logic        clk, rstn, wupd, eupd, rd, ereq, eflag, spi, slp, wkev;
   logic        lupd, rv, wreq, res, done, oen, blk, o1, o2;
   logic [20:0] tgt, pins, dir, wen_m, wdis_m, ris_m, fal_m, wen, efall;
   logic [10:0] oth;
   logic [1:0]  own, hi_m, lo_m, pull;
   logic [31:0] rdata;
   int          err_total, comparisons;
   // ------------------------------------------------------------
   // Instances and tasks
   // ------------------------------------------------------------
   pwoc_pin_model i_pwoc_pin_model (.target(tgt), .pins(pins));
   pwoc_top i_pwoc_top (.clk(clk), .rstn(rstn), .general_io_pin(pins),
      .pin_is_input(dir), .wake_en_upd(wupd), .wake_enable_mask(wen_m),
      .wake_disable_mask(wdis_m), .edge_upd(eupd), .rising_edge_mask(ris_m),
      .falling_edge_mask(fal_m), .other_events(oth), .status_rd(rd),
      .status_rdata(rdata), .status_rvalid(rv), .wake_enable(wen),
      .edge_falling(efall), .wake_req(wreq), .sleep_active(slp),
      .wake_event(wkev), .outputs_en_req(ereq), .outputs_enable_flag(eflag),
      .outputs_en_result(res), .outputs_en_done(done),
      .spi_owns_outputs(spi), .per_owns_outputs(own), .out_lvl_upd(lupd),
      .output_high_mask(hi_m), .output_low_mask(lo_m),
      .outputs_enabled(oen), .spi_timer_block(blk),
      .general_output_first(o1), .general_output_second(o2),
      .output_pullup_en(pull));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task step;
      @(posedge clk);
      #5;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task print_verdict;
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task wake(input logic [20:0] e, input logic [20:0] d);
      step;
      wen_m = e;
      wdis_m = d;
      wupd = 1'b1;
      step;
      wupd = 1'b0;
   endtask
   task edg(input logic [20:0] r, input logic [20:0] f);
      ris_m = r;
      fal_m = f;
      eupd = 1'b1;
      step;
      eupd = 1'b0;
   endtask
   task lvl(input logic [1:0] h, input logic [1:0] l, input logic [1:0] e);
      hi_m = h;
      lo_m = l;
      lupd = 1'b1;
      step;
      lupd = 1'b0;
      step;
      chk("levels", {30'h0, e}, {30'h0, o2, o1});
   endtask
   task oreq(input logic f, input logic e);
      step;
      eflag = f;
      ereq = 1'b1;
      step;
      ereq = 1'b0;
      chk("done", 32'h1, {31'h0, done});
      chk("result", {31'h0, e}, {31'h0, res});
   endtask
   task rd_st(input logic [31:0] e);
      step;
      rd = 1'b1;
      step;
      rd = 1'b0;
      chk("rvalid", 32'h1, {31'h0, rv});
      chk("status", e, rdata);
   endtask
   task wait_wreq;
      int i;
      for (i = 0; i < 20 && wreq !== 1'b1; i++) step;
      if (wreq !== 1'b1) begin
         $display("[ERR] wake_req expected 1 seen %b", wreq);
         err_total++;
         print_verdict;
      end
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      {rstn, wupd, eupd, rd, ereq, eflag, spi, slp, wkev, lupd} = '0;
      {tgt, wen_m, wdis_m, ris_m, fal_m, oth, own, hi_m, lo_m} = '0;
      dir = 21'h0f_ffff;
      err_total = 0;
      comparisons = 0;
      repeat (12) step;
      rstn = 1'b1;
      step;
      chk("edges", 32'h0, {11'h0, efall});
      chk("levels", 32'h3, {30'h0, o2, o1});
      chk("pullups", 32'h3, {30'h0, pull});
      wake(21'h10_0007, 21'h00_0002);
      chk("enables", 32'h5, {11'h0, wen});
      wake(21'h00_0000, 21'h00_0000);
      chk("enables", 32'h5, {11'h0, wen});
      edg(21'h00_0008, 21'h10_000c);
      chk("edges", 32'h4, {11'h0, efall});
      tgt = 21'h00_0004;
      repeat (6) step;
      rd_st(32'h0000_0000);
      tgt = 21'h00_0000;
      wait_wreq;
      oth = 11'h001;
      step;
      oth = 11'h000;
      rd_st(32'h0020_0004);
      rd_st(32'h0000_0000);
      slp = 1'b1;
      step;
      slp = 1'b0;
      wkev = 1'b1;
      step;
      wkev = 1'b0;
      chk("enables", 32'h5, {11'h0, wen});
      chk("edges", 32'h4, {11'h0, efall});
      spi = 1'b1;
      oreq(1'b1, 1'b0);
      chk("enabled", 32'h0, {31'h0, oen});
      spi = 1'b0;
      oreq(1'b1, 1'b1);
      chk("block", 32'h1, {31'h0, blk});
      chk("pullups", 32'h0, {30'h0, pull});
      lvl(2'b00, 2'b01, 2'b10);
      lvl(2'b01, 2'b00, 2'b11);
      lvl(2'b10, 2'b10, 2'b01);
      lvl(2'b00, 2'b00, 2'b01);
      own = 2'b01;
      lvl(2'b00, 2'b01, 2'b01);
      own = 2'b00;
      step;
      step;
      chk("levels", 32'h0, {30'h0, o2, o1});
      wkev = 1'b1;
      step;
      wkev = 1'b0;
      chk("enabled", 32'h0, {31'h0, oen});
      oreq(1'b0, 1'b1);
      // Mid-run full reset drops latched events and settings
      oth = 11'h002;
      step;
      oth = 11'h000;
      rstn = 1'b0;
      repeat (3) step;
      rstn = 1'b1;
      rd_st(32'h0000_0000);
      chk("enables", 32'h0, {11'h0, wen});
      chk("levels", 32'h3, {30'h0, o2, o1});
      print_verdict;
   end
endmodule
